// *** rtl/lssc_pkg.sv ***
// shared constants and types of the lo synthesizer serial control block
package lssc_pkg;

    // serial frame layout: one direction bit, address, data
    localparam int         FRAME_ADDR_BITS = 16;
    localparam int         FRAME_DATA_BITS = 8;
    localparam logic [4:0] BIT_DIR         = 5'h00;
    localparam logic [4:0] BIT_ADDR_LAST   = 5'h10;
    localparam logic [4:0] BIT_DATA_FIRST  = 5'h11;
    localparam logic [4:0] BIT_DATA_LAST   = 5'h18;
    localparam logic [4:0] BIT_DONE        = 5'h19;

    // register offsets
    localparam logic [15:0] ADDR_IF_CONFIG   = 16'h0000;
    localparam logic [15:0] ADDR_IO_LEVEL_A  = 16'h0101;
    localparam logic [15:0] ADDR_PLL_BLOCKS  = 16'h1021;
    localparam logic [15:0] ADDR_INT_LOW     = 16'h1200;
    localparam logic [15:0] ADDR_FB_DIV      = 16'h120B;
    localparam logic [15:0] ADDR_VCO_SELECT  = 16'h1217;
    localparam logic [15:0] ADDR_CAL_CTRL    = 16'h121F;
    localparam logic [15:0] ADDR_SDM_CTRL    = 16'h122A;
    localparam logic [15:0] ADDR_PFD_CP      = 16'h122D;
    localparam logic [15:0] ADDR_VCO_ADJUST  = 16'h1240;
    localparam logic [15:0] ADDR_LOCK_STATUS = 16'h124D;
    localparam logic [15:0] ADDR_IO_LEVEL_B  = 16'h1401;
    localparam logic [15:0] ADDR_LO_PATH     = 16'h1414;

    // field positions
    localparam int FOUR_WIRE_SELECT_LO = 3;
    localparam int FOUR_WIRE_SELECT_HI = 4;
    localparam int IO_LEVEL_SELECT_A   = 0;
    localparam int IO_LEVEL_SELECT_B   = 4;
    localparam int LOCK_OBSERVE_CTRL   = 1;
    localparam int LOCK_STATUS_BIT     = 0;
    localparam int MIXER_LO_ENABLE     = 7;
    localparam int LO_DIVIDE_RATIO_MSB = 4;

    // reset value of every writable register
    localparam logic [7:0] REG_RESET = 8'h00;

    // values that together select the external lo path
    localparam logic [7:0] EXT_FB_DIV     = 8'h00;
    localparam logic [7:0] EXT_PFD_CP     = 8'h00;
    localparam logic [7:0] EXT_VCO_ADJUST = 8'h03;
    localparam logic [7:0] EXT_VCO_SELECT = 8'h00;
    localparam logic [7:0] EXT_CAL_CTRL   = 8'h40;
    localparam logic [7:0] EXT_PLL_BLOCKS = 8'hD8;
    localparam logic [7:0] EXT_LO_PATH    = 8'hA1;

    // one-hot lo divide ratios
    localparam logic [4:0] LO_DIV_16 = 5'h10;
    localparam logic [4:0] LO_DIV_8  = 5'h08;
    localparam logic [4:0] LO_DIV_4  = 5'h04;
    localparam logic [4:0] LO_DIV_2  = 5'h02;
    localparam logic [4:0] LO_DIV_1  = 5'h01;

    // timing
    localparam int SYS_CLK_PERIOD_NS = 20;
    localparam int LOOP_BW_KHZ       = 20;
    localparam int CAL_TIME_US       = 200;
    localparam int SETTLE_TIME_US    = 200;
    localparam int CAL_CYCLES_DEF    =
        (CAL_TIME_US * 1000 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int SETTLE_CYCLES_DEF =
        (SETTLE_TIME_US * 1000 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

    typedef enum {
        LOCK_IDLE,
        LOCK_CALIBRATE,
        LOCK_SETTLE,
        LOCK_HELD
    } lssc_lock_state_t;

endpackage : lssc_pkg

// *** rtl/lssc_pll_if.sv ***
// carrier between the serial control top and the lock sequencer
`timescale 1ns/1ps
`default_nettype none
interface lssc_pll_if;
    logic calStart;
    logic extLoMode;
    logic locked;
    logic calibrating;

    modport ctrl (output calStart, output extLoMode,
                  input locked, input calibrating);
    modport seq (input calStart, input extLoMode,
                 output locked, output calibrating);
endinterface : lssc_pll_if
`default_nettype wire

// *** rtl/lssc_lock_seq.sv ***
// vco band calibration and loop settling sequencer
`timescale 1ns/1ps
`default_nettype none
module lssc_lock_seq
    import lssc_pkg::*;
#(
    parameter int CAL_CYCLES    = CAL_CYCLES_DEF,
    parameter int SETTLE_CYCLES = SETTLE_CYCLES_DEF
) (
    // clock and reset
    input  wire logic  clk,
    input  wire logic  rstN,
    // control and status
    lssc_pll_if.seq    pll
);

    localparam int MAX_CYCLES =
        (CAL_CYCLES > SETTLE_CYCLES) ? CAL_CYCLES : SETTLE_CYCLES;
    localparam int CW = $clog2(MAX_CYCLES + 1);
    localparam logic [CW-1:0] CAL_LOAD    = CW'(CAL_CYCLES - 1);
    localparam logic [CW-1:0] SETTLE_LOAD = CW'(SETTLE_CYCLES - 1);

    lssc_lock_state_t state;
    logic [CW-1:0]    count;

    // outside external lo mode a new start restarts from any state, so lock drops at once
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state <= LOCK_IDLE;
            count <= '0;
        end else if (pll.extLoMode) begin
            state <= LOCK_IDLE;
            count <= '0;
        end else if (pll.calStart) begin
            state <= LOCK_CALIBRATE;
            count <= CAL_LOAD;
        end else begin
            unique case (state)
                LOCK_IDLE: begin
                    count <= '0;
                end
                LOCK_CALIBRATE: begin
                    if (count == '0) begin
                        state <= LOCK_SETTLE;
                        count <= SETTLE_LOAD;
                    end else begin
                        count <= count - 1'b1;
                    end
                end
                LOCK_SETTLE: begin
                    if (count == '0) begin
                        state <= LOCK_HELD;
                    end else begin
                        count <= count - 1'b1;
                    end
                end
                LOCK_HELD: begin
                    count <= '0;
                end
            endcase
        end
    end

    assign pll.locked      = (state == LOCK_HELD);
    assign pll.calibrating = (state == LOCK_CALIBRATE);

endmodule : lssc_lock_seq
`default_nettype wire

// *** rtl/lssc_serial_ctrl.sv ***
// serial register port and lo synthesizer control top
`timescale 1ns/1ps
`default_nettype none
module lssc_serial_ctrl
    import lssc_pkg::*;
#(
    parameter int CAL_CYCLES    = CAL_CYCLES_DEF,
    parameter int SETTLE_CYCLES = SETTLE_CYCLES_DEF
) (
    // system clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // serial link
    input  wire logic        spiSclk,
    input  wire logic        spiCsN,
    input  wire logic        sdioIn,
    output logic             sdioOut,
    output logic             sdioOe,
    output logic             sdoOut,
    output logic             sdoOe,
    // synthesizer status
    output logic             lockIndicatorPin,
    output logic             pllCalibrating,
    // configuration seen by the analog side
    output logic             fourWireSelect,
    output logic             ioLevelSelect33,
    output logic [4:0]       loDivideRatio,
    output logic             loDivideValid,
    output logic             mixerLoEnable,
    output logic             externalLoActive
);

    // ---- system reset, released through two flip-flops
    logic rstMeta;
    logic rstSyncN;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta  <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta  <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    // ---- link domain: frame position
    // select high clears the frame asynchronously, so sclk edges and
    // data outside a frame never reach the shifters
    logic       frameReset;
    logic [4:0] bitCount;
    logic       readFrame;
    logic [15:0] addrShift;
    logic [6:0]  dataShift;
    logic [7:0]  writeData;
    logic        writeCommit;

    assign frameReset = spiCsN | ~rstSyncN;

    always_ff @(posedge spiSclk or posedge frameReset) begin
        if (frameReset) begin
            bitCount <= BIT_DIR;
        end else if (bitCount != BIT_DONE) begin
            bitCount <= bitCount + 5'h01;
        end
    end

    // direction bit: high reads, low writes
    always_ff @(posedge spiSclk or posedge frameReset) begin
        if (frameReset) begin
            readFrame <= 1'b0;
        end else if (bitCount == BIT_DIR) begin
            readFrame <= sdioIn;
        end
    end

    // address shifts in msb first
    always_ff @(posedge spiSclk or posedge frameReset) begin
        if (frameReset) begin
            addrShift <= 16'h0000;
        end else if (bitCount != BIT_DIR && bitCount <= BIT_ADDR_LAST) begin
            addrShift <= {addrShift[14:0], sdioIn};
        end
    end

    // data shifts in msb first; the last bit joins at the commit edge
    always_ff @(posedge spiSclk or posedge frameReset) begin
        if (frameReset) begin
            dataShift <= 7'h00;
        end else if (bitCount >= BIT_DATA_FIRST && bitCount < BIT_DATA_LAST)
        begin
            dataShift <= {dataShift[5:0], sdioIn};
        end
    end

    assign writeData   = {dataShift, sdioIn};
    assign writeCommit = !spiCsN && !readFrame
                       && (bitCount == BIT_DATA_LAST);

    // ---- link domain: writable registers
    // these sit on sclk because the host only moves them inside frames;
    // the analog side sees them as static levels
    logic [7:0] regIfConfig;
    logic [7:0] regIoLevelA;
    logic [7:0] regPllBlocks;
    logic [7:0] regIntLow;
    logic [7:0] regFbDiv;
    logic [7:0] regVcoSelect;
    logic [7:0] regCalCtrl;
    logic [7:0] regSdmCtrl;
    logic [7:0] regPfdCp;
    logic [7:0] regVcoAdjust;
    logic [7:0] regIoLevelB;
    logic [7:0] regLoPath;

    always_ff @(posedge spiSclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            regIfConfig  <= REG_RESET;
            regIoLevelA  <= REG_RESET;
            regPllBlocks <= REG_RESET;
            regIntLow    <= REG_RESET;
            regFbDiv     <= REG_RESET;
            regVcoSelect <= REG_RESET;
            regCalCtrl   <= REG_RESET;
            regSdmCtrl   <= REG_RESET;
            regPfdCp     <= REG_RESET;
            regVcoAdjust <= REG_RESET;
            regIoLevelB  <= REG_RESET;
            regLoPath    <= REG_RESET;
        end else if (writeCommit) begin
            // the lock status register is read-only; unknown offsets drop
            unique case (addrShift)
                ADDR_IF_CONFIG:  regIfConfig  <= writeData;
                ADDR_IO_LEVEL_A: regIoLevelA  <= writeData;
                ADDR_PLL_BLOCKS: regPllBlocks <= writeData;
                ADDR_INT_LOW:    regIntLow    <= writeData;
                ADDR_FB_DIV:     regFbDiv     <= writeData;
                ADDR_VCO_SELECT: regVcoSelect <= writeData;
                ADDR_CAL_CTRL:   regCalCtrl   <= writeData;
                ADDR_SDM_CTRL:   regSdmCtrl   <= writeData;
                ADDR_PFD_CP:     regPfdCp     <= writeData;
                ADDR_VCO_ADJUST: regVcoAdjust <= writeData;
                ADDR_IO_LEVEL_B: regIoLevelB  <= writeData;
                ADDR_LO_PATH:    regLoPath    <= writeData;
                default: begin
                end
            endcase
        end
    end

    // ---- link domain: calibration start event
    // a toggle survives the crossing even if sclk stops right after it
    logic calToggle;

    always_ff @(posedge spiSclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            calToggle <= 1'b0;
        end else if (writeCommit && addrShift == ADDR_INT_LOW) begin
            calToggle <= ~calToggle;
        end
    end

    // ---- link domain: external lo detection
    // one match flag per register, each updated only by its own write,
    // so the and of them never glitches when a single flag changes
    logic [6:0] extMatch;
    logic       extLoMatch;

    always_ff @(posedge spiSclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            extMatch <= 7'h00;
        end else if (writeCommit) begin
            unique case (addrShift)
                ADDR_FB_DIV:     extMatch[0] <= (writeData == EXT_FB_DIV);
                ADDR_PFD_CP:     extMatch[1] <= (writeData == EXT_PFD_CP);
                ADDR_VCO_ADJUST: extMatch[2] <= (writeData == EXT_VCO_ADJUST);
                ADDR_VCO_SELECT: extMatch[3] <= (writeData == EXT_VCO_SELECT);
                ADDR_CAL_CTRL:   extMatch[4] <= (writeData == EXT_CAL_CTRL);
                ADDR_PLL_BLOCKS: extMatch[5] <= (writeData == EXT_PLL_BLOCKS);
                ADDR_LO_PATH:    extMatch[6] <= (writeData == EXT_LO_PATH);
                default: begin
                end
            endcase
        end
    end

    assign extLoMatch = &extMatch;

    // ---- link domain: lock status brought over from sys_clk
    // sclk idles between frames; the direction and sixteen address edges refresh it
    // long before the data phase needs it
    logic lockStatus;
    logic lockSpiMeta;
    logic lockSpi;

    always_ff @(posedge spiSclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            lockSpiMeta <= 1'b0;
            lockSpi     <= 1'b0;
        end else begin
            lockSpiMeta <= lockStatus;
            lockSpi     <= lockSpiMeta;
        end
    end

    // ---- link domain: read data
    logic [7:0] readData;

    always_comb begin
        unique case (addrShift)
            ADDR_IF_CONFIG:   readData = regIfConfig;
            ADDR_IO_LEVEL_A:  readData = regIoLevelA;
            ADDR_PLL_BLOCKS:  readData = regPllBlocks;
            ADDR_INT_LOW:     readData = regIntLow;
            ADDR_FB_DIV:      readData = regFbDiv;
            ADDR_VCO_SELECT:  readData = regVcoSelect;
            ADDR_CAL_CTRL:    readData = regCalCtrl;
            ADDR_SDM_CTRL:    readData = regSdmCtrl;
            ADDR_PFD_CP:      readData = regPfdCp;
            ADDR_VCO_ADJUST:  readData = regVcoAdjust;
            ADDR_IO_LEVEL_B:  readData = regIoLevelB;
            ADDR_LO_PATH:     readData = regLoPath;
            ADDR_LOCK_STATUS: readData = {7'h00, lockSpi};
            default:          readData = 8'h00;
        endcase
    end

    // read bits change on the falling edge so the host samples them
    // stable on the next rising edge
    logic [7:0] readShift;

    always_ff @(negedge spiSclk or posedge frameReset) begin
        if (frameReset) begin
            readShift <= 8'h00;
        end else if (bitCount == BIT_DATA_FIRST) begin
            readShift <= readData;
        end else if (bitCount > BIT_DATA_FIRST) begin
            readShift <= {readShift[6:0], 1'b0};
        end
    end

    // ---- link domain: pin direction
    logic readPhase;

    assign fourWireSelect = regIfConfig[FOUR_WIRE_SELECT_HI]
                          & regIfConfig[FOUR_WIRE_SELECT_LO];
    assign readPhase = !spiCsN && readFrame
                     && (bitCount >= BIT_DATA_FIRST)
                     && (bitCount != BIT_DONE);
    assign sdioOut   = readShift[7];
    assign sdioOe    = readPhase && !fourWireSelect;
    assign sdoOut    = readShift[7];
    assign sdoOe     = readPhase && fourWireSelect;

    // ---- system domain: crossings from the link
    logic calSyncMeta;
    logic calSync;
    logic calSyncLast;
    logic extSyncMeta;
    logic extSync;
    logic obsSyncMeta;
    logic obsSync;

    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            calSyncMeta <= 1'b0;
            calSync     <= 1'b0;
            calSyncLast <= 1'b0;
        end else begin
            calSyncMeta <= calToggle;
            calSync     <= calSyncMeta;
            calSyncLast <= calSync;
        end
    end

    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            extSyncMeta <= 1'b0;
            extSync     <= 1'b0;
            obsSyncMeta <= 1'b0;
            obsSync     <= 1'b0;
        end else begin
            extSyncMeta <= extLoMatch;
            extSync     <= extSyncMeta;
            obsSyncMeta <= regSdmCtrl[LOCK_OBSERVE_CTRL];
            obsSync     <= obsSyncMeta;
        end
    end

    // ---- system domain: lock sequencer
    lssc_pll_if pllBus ();

    assign pllBus.calStart  = calSync ^ calSyncLast;
    assign pllBus.extLoMode = extSync;

    lssc_lock_seq #(
        .CAL_CYCLES    (CAL_CYCLES),
        .SETTLE_CYCLES (SETTLE_CYCLES)
    ) u_lock_seq (
        .clk  (sys_clk),
        .rstN (rstSyncN),
        .pll  (pllBus.seq)
    );

    // lock is hidden while the observe control bit stays set
    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            lockStatus <= 1'b0;
        end else begin
            lockStatus <= pllBus.locked && !obsSync;
        end
    end

    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            pllCalibrating <= 1'b0;
        end else begin
            pllCalibrating <= pllBus.calibrating;
        end
    end

    assign lockIndicatorPin = lockStatus;

    // ---- configuration outputs
    // the host is trusted to set the mixer enable only after lock
    assign mixerLoEnable    = regLoPath[MIXER_LO_ENABLE];
    assign loDivideRatio    = regLoPath[LO_DIVIDE_RATIO_MSB:0];
    assign ioLevelSelect33  = regIoLevelA[IO_LEVEL_SELECT_A]
                            & regIoLevelB[IO_LEVEL_SELECT_B];
    assign externalLoActive = extLoMatch;

    // illegal codes leave the divider unselected
    always_comb begin
        unique case (loDivideRatio)
            LO_DIV_16: loDivideValid = 1'b1;
            LO_DIV_8:  loDivideValid = 1'b1;
            LO_DIV_4:  loDivideValid = 1'b1;
            LO_DIV_2:  loDivideValid = 1'b1;
            LO_DIV_1:  loDivideValid = extLoMatch;
            default:   loDivideValid = 1'b0;
        endcase
    end

endmodule : lssc_serial_ctrl
`default_nettype wire

// *** dv/lssc_serial_ctrl_assertions.sv ***
// concurrent checks on the serial control top ports
`timescale 1ns/1ps
`default_nettype none
module lssc_serial_ctrl_checker
    import lssc_pkg::*;
#(
    parameter int CAL_CYCLES    = CAL_CYCLES_DEF,
    parameter int SETTLE_CYCLES = SETTLE_CYCLES_DEF
) (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       rstn,
    // serial link
    input wire logic       spiSclk,
    input wire logic       spiCsN,
    input wire logic       sdioIn,
    input wire logic       sdioOut,
    input wire logic       sdioOe,
    input wire logic       sdoOut,
    input wire logic       sdoOe,
    // status and configuration
    input wire logic       lockIndicatorPin,
    input wire logic       pllCalibrating,
    input wire logic       fourWireSelect,
    input wire logic       ioLevelSelect33,
    input wire logic [4:0] loDivideRatio,
    input wire logic       loDivideValid,
    input wire logic       mixerLoEnable,
    input wire logic       externalLoActive
);
    int calRun;
    int sinceCal;
    default clocking sysCb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // run lengths kept in counters: too long for a repetition
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            calRun   <= 0;
            sinceCal <= 0;
        end else begin
            calRun   <= pllCalibrating ? calRun + 1 : 0;
            sinceCal <= pllCalibrating ? 0 : sinceCal + 1;
        end
    end
    chk_select_idle_quiet: assert property (
        spiCsN |-> !sdioOe && !sdoOe) else $error("driven while idle");
    chk_data_pin_three: assert property (
        sdioOe |-> !fourWireSelect) else $error("data pin in four-wire");
    chk_out_pin_four: assert property (
        sdoOe |-> fourWireSelect) else $error("output pin in three-wire");
    chk_cal_length: assert property (
        $fell(pllCalibrating) |-> calRun == CAL_CYCLES)
        else $error("calibration length wrong");
    chk_settle_before_lock: assert property (
        $rose(lockIndicatorPin) |-> sinceCal >= SETTLE_CYCLES)
        else $error("lock before settling");
    chk_lock_low_cal: assert property (
        pllCalibrating && $past(pllCalibrating, 3) |-> !lockIndicatorPin)
        else $error("lock shown during calibration");
    chk_divide_valid_map: assert property (
        $stable(loDivideRatio) && $stable(externalLoActive) |->
        loDivideValid == (loDivideRatio inside {5'h10, 5'h08, 5'h04, 5'h02}
        || (loDivideRatio == 5'h01 && externalLoActive)))
        else $error("divide valid wrong");
    chk_ext_lo_path: assert property (
        externalLoActive && $past(externalLoActive) |->
        loDivideRatio == LO_DIV_1 && mixerLoEnable)
        else $error("external path not divide-by-one");
    chk_ext_no_cal: assert property (
        externalLoActive && $past(externalLoActive, 8) |-> !pllCalibrating)
        else $error("calibration in external mode");
endmodule : lssc_serial_ctrl_checker
bind lssc_serial_ctrl lssc_serial_ctrl_checker #(.CAL_CYCLES(CAL_CYCLES),
    .SETTLE_CYCLES(SETTLE_CYCLES)) checker_i (.sys_clk, .rstn, .spiSclk,
    .spiCsN, .sdioIn, .sdioOut, .sdioOe, .sdoOut, .sdoOe, .lockIndicatorPin,
    .pllCalibrating, .fourWireSelect, .ioLevelSelect33, .loDivideRatio,
    .loDivideValid, .mixerLoEnable, .externalLoActive);
`default_nettype wire

// *** dv/lssc_host_model.sv ***
// host serial master that frames register accesses
`timescale 1ns/1ps
`default_nettype none
module lssc_host_model (
    // serial link
    output logic      spiSclk,
    output logic      spiCsN,
    output logic      hostData,
    output logic      hostOe,
    input  wire logic sdioWire,
    input  wire logic sdoPin
);
    // clock stands low between frames
    initial begin
        spiSclk  = 1'b0;
        spiCsN   = 1'b1;
        hostData = 1'b0;
        hostOe   = 1'b0;
    end
    task automatic frame(input logic rd, input logic [15:0] addr,
        input logic [7:0] wr, input logic fourW, output logic [7:0] rdv);
        logic [24:0] bits;
        bits = {rd, addr, wr};
        rdv = 8'h00;
        #13;
        spiCsN = 1'b0;
        for (int k = 0; k < 25; k++) begin
            hostOe   = !(rd && !fourW && k > 16);
            hostData = bits[24 - k];
            #62.5;
            spiSclk = 1'b1;
            if (k > 16) rdv = {rdv[6:0], fourW ? sdoPin : sdioWire};
            #62.5;
            spiSclk = 1'b0;
        end
        hostOe = 1'b0;
        #62.5;
        spiCsN = 1'b1;
        #125;
    endtask : frame
endmodule : lssc_host_model
`default_nettype wire

// *** dv/lo_synth_serial_control_tb.sv ***
// self-checking bench of the serial control top
`timescale 1ns/1ps
`default_nettype none
module lo_synth_serial_control_tb;
    import lssc_pkg::*;
    localparam int CAL = 20;
    localparam int SET = 30;
    logic sysClk, rstN, spiSclk, spiCsN, sdioIn, hostData, hostOe;
    logic sdioOut, sdioOe, sdoOut, sdoOe, lockIndicatorPin, pllCalibrating;
    logic fourWireSelect, ioLevelSelect33, loDivideValid, mixerLoEnable;
    logic externalLoActive, fourWire;
    logic idleLevel = 1'b0;
    logic [4:0] loDivideRatio;
    int fails, check_count;
    logic [7:0] divTab [5] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h83};
    logic [15:0] extAddr [7] = '{ADDR_FB_DIV, ADDR_PFD_CP, ADDR_VCO_ADJUST,
        ADDR_VCO_SELECT, ADDR_CAL_CTRL, ADDR_PLL_BLOCKS, ADDR_LO_PATH};
    logic [7:0] extVal [7] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h40, 8'hD8,
        8'hA1};
    // released data line wanders so a stale value cannot pass
    assign sdioIn = sdioOe ? sdioOut : (hostOe ? hostData : idleLevel);
    always @(posedge sysClk) idleLevel <= ~idleLevel;
    lssc_serial_ctrl #(.CAL_CYCLES(CAL), .SETTLE_CYCLES(SET))
        lssc_serial_ctrl_i (.sys_clk(sysClk), .rstn(rstN), .spiSclk,
        .spiCsN, .sdioIn, .sdioOut, .sdioOe, .sdoOut, .sdoOe,
        .lockIndicatorPin, .pllCalibrating, .fourWireSelect,
        .ioLevelSelect33, .loDivideRatio, .loDivideValid, .mixerLoEnable,
        .externalLoActive);
    // released output pin wanders too, so a read that skips its enable fails
    lssc_host_model lssc_host_model_i (.spiSclk, .spiCsN, .hostData,
        .hostOe, .sdioWire(sdioIn),
        .sdoPin(sdoOe ? sdoOut : idleLevel));
    initial begin
        sysClk = 1'b0;
        forever #10 sysClk = ~sysClk;
    end
    task automatic compare(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : compare
    task automatic regWrite(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] unused;
        lssc_host_model_i.frame(1'b0, a, d, fourWire, unused);
    endtask : regWrite
    task automatic regRead(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] got;
        lssc_host_model_i.frame(1'b1, a, 8'h00, fourWire, got);
        compare("register read", exp, got);
    endtask : regRead
    task automatic calibrate();
        int n;
        regWrite(ADDR_INT_LOW, 8'h40);
        compare("lock in cal", 8'h00, {7'h00, lockIndicatorPin});
        n = 0;
        while (pllCalibrating === 1'b1 && n < 100) begin
            @(negedge sysClk);
            n++;
        end
        n = 0;
        while (lockIndicatorPin !== 1'b1 && n < 100) begin
            @(negedge sysClk);
            n++;
        end
        compare("settle", 8'h01, {7'h00, n >= SET - 1 && n <= SET + 4});
    endtask : calibrate
    task automatic end_of_test();
        if (fails == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #500us;
        fails++;
        end_of_test();
    end
    initial begin
        rstN = 1'b0;
        fourWire = 1'b0;
        fails = 0;
        check_count = 0;
        repeat (20) @(posedge sysClk);
        rstN <= 1'b1;
        repeat (5) @(posedge sysClk);
        regRead(ADDR_IF_CONFIG, REG_RESET);
        regWrite(ADDR_SDM_CTRL, 8'hA5);
        regRead(ADDR_SDM_CTRL, 8'hA5);
        regWrite(16'h1234, 8'h5A);
        regRead(16'h1234, 8'h00);
        regWrite(ADDR_LOCK_STATUS, 8'hFF);
        regRead(ADDR_LOCK_STATUS, 8'h00);
        regWrite(ADDR_SDM_CTRL, 8'h00);
        calibrate();
        regRead(ADDR_LOCK_STATUS, 8'h01);
        calibrate();
        regWrite(ADDR_SDM_CTRL, 8'h02);
        compare("lock hidden", 8'h00, {7'h00, lockIndicatorPin});
        regWrite(ADDR_SDM_CTRL, 8'h00);
        for (int i = 0; i < 5; i++) begin
            regWrite(ADDR_LO_PATH, divTab[i]);
            compare("valid", {7'h00, i < 4}, {7'h00, loDivideValid});
            compare("mixer", {7'h00, divTab[i][7]}, {7'h00, mixerLoEnable});
        end
        regWrite(ADDR_IO_LEVEL_A, 8'h01);
        compare("level", 8'h00, {7'h00, ioLevelSelect33});
        regWrite(ADDR_IO_LEVEL_B, 8'h10);
        compare("level", 8'h01, {7'h00, ioLevelSelect33});
        regWrite(ADDR_IF_CONFIG, 8'h18);
        fourWire = 1'b1;
        compare("four wire", 8'h01, {7'h00, fourWireSelect});
        regRead(ADDR_LO_PATH, 8'h83);
        regWrite(ADDR_IF_CONFIG, 8'h08);
        fourWire = 1'b0;
        compare("four wire", 8'h00, {7'h00, fourWireSelect});
        regRead(ADDR_IF_CONFIG, 8'h08);
        for (int i = 0; i < 7; i++) regWrite(extAddr[i], extVal[i]);
        compare("ext lo", 8'h01, {7'h00, externalLoActive});
        compare("valid", 8'h01, {7'h00, loDivideValid});
        regWrite(ADDR_INT_LOW, 8'h40);
        repeat (10) @(negedge sysClk);
        compare("ext cal", 8'h00, {7'h00, pllCalibrating});
        end_of_test();
    end
endmodule : lo_synth_serial_control_tb
`default_nettype wire
